// *** verilog/stp_pkg.sv ***
// Purpose: shared constants, carriers and helpers of the serial transmitter
// Assumes: 8-bit register port, 12-bit baud divisor
// Notes:   offsets are register indices on the plain register port
package stp_pkg;

  // ----------------------------------------------------------------
  // widths and register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DIV_W  = 12;

  localparam logic [ADDR_W-1:0] OFS_DATA     = 3'h0;  // serial_data_register
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 3'h1;  // serial_status_register
  localparam logic [ADDR_W-1:0] OFS_CONTROL  = 3'h2;  // serial_control_register
  localparam logic [ADDR_W-1:0] OFS_FRAME    = 3'h3;  // frame_control_register / baud_divisor_high
  localparam logic [ADDR_W-1:0] OFS_BAUD_LOW = 3'h4;  // baud_divisor_low

  // status field positions
  localparam int unsigned ST_RX_DONE   = 7;
  localparam int unsigned ST_TX_DONE   = 6;
  localparam int unsigned ST_BUF_EMPTY = 5;
  localparam int unsigned ST_DOUBLE    = 1;
  // control field positions
  localparam int unsigned CT_TXC_IE = 6;
  localparam int unsigned CT_BUF_IE = 5;
  localparam int unsigned CT_TX_EN  = 3;
  localparam int unsigned CT_SIZE2  = 2;
  localparam int unsigned CT_NINTH  = 0;
  // frame control field positions
  localparam int unsigned FC_SELECT   = 7;
  localparam int unsigned FC_SYNC     = 6;
  localparam int unsigned FC_PAR_EN   = 5;
  localparam int unsigned FC_PAR_ODD  = 4;
  localparam int unsigned FC_TWO_STOP = 3;
  localparam int unsigned FC_SIZE_HI  = 2;
  localparam int unsigned FC_SIZE_LO  = 1;
  localparam int unsigned FC_POL      = 0;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [1:0]       RST_SIZE_LOW    = 2'h3;   // eight data bits
  localparam logic [DIV_W-1:0] RST_BAUD        = 12'h000;
  localparam logic [4:0]       PRESCALE_NORMAL = 5'h10;
  localparam logic [4:0]       PRESCALE_DOUBLE = 5'h08;
  localparam logic [2:0]       SIZE_NINE       = 3'h7;
  localparam logic [3:0]       BITS_NINE       = 4'h9;
  localparam logic [3:0]       BITS_EIGHT      = 4'h8;
  localparam logic [3:0]       BITS_MIN        = 4'h5;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } stp_bus_req_t;

  typedef struct packed {
    logic       par_en;
    logic       par_odd;
    logic       two_stop;
    logic       sync;
    logic       pol;
    logic [2:0] size;
  } stp_frame_t;

  typedef enum logic [4:0] {
    S_IDLE   = 5'b00001,
    S_START  = 5'b00010,
    S_DATA   = 5'b00100,
    S_PARITY = 5'b01000,
    S_STOP   = 5'b10000
  } stp_state_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // character size code to data bit count; reserved codes act as eight
  function automatic logic [3:0] stp_data_bits(input logic [2:0] code);
    if (code == SIZE_NINE) begin
      return BITS_NINE;
    end else if (code[2] == 1'b0) begin
      return BITS_MIN + {2'h0, code[1:0]};
    end
    return BITS_EIGHT;
  endfunction : stp_data_bits

  // clear every bit at or above the character size
  function automatic logic [8:0] stp_mask(input logic [8:0] data, input logic [3:0] nbits);
    logic [8:0] m;
    m = '0;
    for (int i = 0; i < 9; i++) begin
      m[i] = data[i] & (4'(i) < nbits);
    end
    return m;
  endfunction : stp_mask

endpackage : stp_pkg

// *** verilog/stp_baud_gen.sv ***
// Purpose: baud down-counter producing a tick at every zero
// Assumes: reload_i is a one-cycle pulse on a low divisor byte write
// Notes:   tick rate is clk / (divisor + 1)
module stp_baud_gen #(
  parameter int unsigned DIV_W = 12
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [DIV_W-1:0] divisor_i,
  input  wire logic             reload_i,
  output logic                  tick_o
);

  logic [DIV_W-1:0] count;

  // ----------------------------------------------------------------
  // down-counter
  // ----------------------------------------------------------------
  // reload on zero or on low byte write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (reload_i || count == '0) begin
      count <= divisor_i;
    end else begin
      count <= count - 1'b1;
    end
  end

  assign tick_o = (count == '0);

  a_baud_reload: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tick_o || reload_i) |=> count == $past(divisor_i))
    else $error("baud counter did not reload");

endmodule : stp_baud_gen

// *** verilog/stp_xck_edge.sv ***
// Purpose: synchronise the serial clock pin and pick its data-change edge
// Assumes: pin clock slower than a quarter of clk_i
// Notes:   change_o pulses one cycle, one to two cycles after the pin edge
module stp_xck_edge (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic xck_i,
  input  wire logic pol_i,
  output logic      change_o
);

  logic meta;
  logic sync;
  logic prev;

  // ----------------------------------------------------------------
  // two-stage synchroniser and edge history
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= xck_i;
      sync <= meta;
      prev <= sync;
    end
  end

  assign change_o = pol_i ? (prev & ~sync) : (~prev & sync);

  a_edge_polarity: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    change_o |-> (sync != pol_i) && $changed(sync))
    else $error("data change on the wrong serial clock edge");

endmodule : stp_xck_edge

// *** verilog/stp_serial_tx.sv ***
// Purpose: transmit half of a serial port with parity, one-deep buffer
// Assumes: register port with one-cycle strobes; xck_i is an asynchronous pin
// Notes:   txd_o lags the frame state by one cycle; receiver is not present
//
// Behaviour
// - parity is xor of all data bits
// - odd parity inverts the xor
// - parity sits between last data and stop
// - parity only when parity enable bit set
// - transmit enable takes over the data pin
// - sync mode times bits by serial clock pin
// - data register write loads the buffer
// - buffer moves to idle or finishing shifter
// - frame sent at baud or pin clock rate
// - bits above character size are ignored
// - buffer empty flag mirrors buffer state
// - buffer empty request is level while enabled
// - data write clears buffer empty flag
// - complete flag set when frame done, buffer empty
// - complete flag cleared by service or one-write
// - complete request follows flag when enabled
// - shared address routed by top bit
// - low start, LSB first, high stop, idle high
// - stop select gives one or two stops
// - baud counter reloads on zero or write
// - clock polarity picks data change edge
//
// Strobed register access and the placing of the registers were decided locally.
module stp_serial_tx (
  input  wire logic                  clk_i,
  input  wire logic                  arst_n_i,
  input  wire stp_pkg::stp_bus_req_t bus_i,
  output logic [stp_pkg::DATA_W-1:0] rdata_o,
  output logic                       txd_o,
  output logic                       txd_oe_o,
  input  wire logic                  xck_i,
  input  wire logic                  txc_ack_i,
  output logic                       buf_irq_o,
  output logic                       txc_irq_o
);
  import stp_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  stp_frame_t       frame;
  logic [DIV_W-1:0] divisor;
  logic             double_speed;
  logic             txc_ie;
  logic             buf_ie;
  logic             tx_en;
  logic             ninth;
  logic             tx_done;
  logic             buf_full;
  logic [8:0]       buf_data;
  stp_state_t       state;
  stp_state_t       next_state;
  logic [8:0]       shreg;
  logic [3:0]       bit_cnt;
  logic             stop_cnt;
  logic             par_bit;
  logic [3:0]       pre_cnt;

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  wire wr_data    = bus_i.wr && bus_i.addr == OFS_DATA;
  wire wr_status  = bus_i.wr && bus_i.addr == OFS_STATUS;
  wire wr_control = bus_i.wr && bus_i.addr == OFS_CONTROL;
  wire wr_shared  = bus_i.wr && bus_i.addr == OFS_FRAME;
  wire wr_blow    = bus_i.wr && bus_i.addr == OFS_BAUD_LOW;
  // top bit steers the shared address
  wire wr_frame   = wr_shared && bus_i.wdata[FC_SELECT];
  wire wr_bhigh   = wr_shared && !bus_i.wdata[FC_SELECT];

  wire [3:0] nbits = stp_data_bits(frame.size);

  // ----------------------------------------------------------------
  // bit timing
  // ----------------------------------------------------------------
  logic baud_tick;
  logic xck_change;

  // low byte write reloads the new divisor
  wire [DIV_W-1:0] reload_div = wr_blow ? {divisor[DIV_W-1:DATA_W], bus_i.wdata} : divisor;

  stp_baud_gen #(
    .DIV_W (DIV_W)
  ) u_baud (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n),
    .divisor_i (reload_div),
    .reload_i  (wr_blow),
    .tick_o    (baud_tick)
  );

  stp_xck_edge u_xck (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n),
    .xck_i    (xck_i),
    .pol_i    (frame.pol),
    .change_o (xck_change)
  );

  // divide ticks by 16 or 8, or use pin edge
  wire [4:0] prescale = double_speed ? PRESCALE_DOUBLE : PRESCALE_NORMAL;
  wire       pre_wrap = ({1'b0, pre_cnt} == prescale - 5'h01);
  // sync mode times bits on pin clock
  wire       step     = frame.sync ? xck_change : (baud_tick && pre_wrap);

  // ----------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------
  wire last_data = (bit_cnt == nbits - 4'h1);
  wire last_stop = (state == S_STOP) && (stop_cnt || !frame.two_stop);
  wire frame_end = last_stop && step;
  // load when idle or right after last stop
  wire load = buf_full && tx_en &&
              (((state == S_IDLE) && (!frame.sync || step)) || frame_end);
  // drop bits above the character size
  wire [8:0] load_data = stp_mask(buf_data, nbits);

  // next frame state
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: begin
        if (load) begin
          next_state = S_START;
        end
      end
      S_START: begin
        if (step) begin
          next_state = S_DATA;
        end
      end
      S_DATA: begin
        if (step && last_data) begin
          next_state = frame.par_en ? S_PARITY : S_STOP;
        end
      end
      S_PARITY: begin
        if (step) begin
          next_state = S_STOP;
        end
      end
      S_STOP: begin
        if (frame_end) begin
          next_state = load ? S_START : S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // state register and shifter
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      shreg <= '0;
      bit_cnt <= '0;
      stop_cnt <= 1'b0;
      par_bit <= 1'b0;
    end else begin
      state <= next_state;
      if (load) begin
        shreg <= load_data;
        bit_cnt <= '0;
        stop_cnt <= 1'b0;
        par_bit <= ^load_data ^ frame.par_odd;
      end else if (step && state == S_DATA) begin
        shreg <= {1'b0, shreg[8:1]};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (step && state == S_STOP) begin
        stop_cnt <= 1'b1;
      end
    end
  end

  // prescaler restarts with each frame
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt <= '0;
    end else if (load || (baud_tick && pre_wrap)) begin
      pre_cnt <= '0;
    end else if (baud_tick) begin
      pre_cnt <= pre_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // buffer and flags
  // ----------------------------------------------------------------
  wire [DATA_W-1:0] status_rd = {1'b0, tx_done, !buf_full, 3'h0, double_speed, 1'b0};
  wire              txc_clear = txc_ack_i || (wr_status && bus_i.wdata[ST_TX_DONE]);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      buf_full <= 1'b0;
      buf_data <= '0;
      tx_done <= 1'b0;
    end else begin
      if (wr_data) begin
        buf_full <= 1'b1;
        buf_data <= {ninth, bus_i.wdata};
      end else if (load) begin
        buf_full <= 1'b0;
      end
      if (frame_end && !buf_full) begin
        tx_done <= 1'b1;
      end else if (txc_clear) begin
        tx_done <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      frame <= '{par_en: 1'b0, par_odd: 1'b0, two_stop: 1'b0, sync: 1'b0, pol: 1'b0,
                 size: {1'b0, RST_SIZE_LOW}};
      divisor <= RST_BAUD;
      double_speed <= 1'b0;
      {txc_ie, buf_ie, tx_en, ninth} <= 4'h0;
    end else begin
      if (wr_status) begin
        double_speed <= bus_i.wdata[ST_DOUBLE];
      end
      if (wr_control) begin
        txc_ie <= bus_i.wdata[CT_TXC_IE];
        buf_ie <= bus_i.wdata[CT_BUF_IE];
        tx_en <= bus_i.wdata[CT_TX_EN];
        frame.size[2] <= bus_i.wdata[CT_SIZE2];
        ninth <= bus_i.wdata[CT_NINTH];
      end
      if (wr_frame) begin
        frame.sync <= bus_i.wdata[FC_SYNC];
        frame.par_en <= bus_i.wdata[FC_PAR_EN];
        frame.par_odd <= bus_i.wdata[FC_PAR_ODD];
        frame.two_stop <= bus_i.wdata[FC_TWO_STOP];
        frame.size[1:0] <= bus_i.wdata[FC_SIZE_HI:FC_SIZE_LO];
        frame.pol <= bus_i.wdata[FC_POL];
      end
      if (wr_bhigh) begin
        divisor[DIV_W-1:DATA_W] <= bus_i.wdata[DIV_W-DATA_W-1:0];
      end
      if (wr_blow) begin
        divisor[DATA_W-1:0] <= bus_i.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // read mux and outputs
  // ----------------------------------------------------------------
  wire [DATA_W-1:0] control_rd = {1'b0, txc_ie, buf_ie, 1'b0, tx_en, frame.size[2], 1'b0, ninth};
  wire [DATA_W-1:0] frame_rd   = {1'b1, frame.sync, frame.par_en, frame.par_odd, frame.two_stop,
                                  frame.size[1:0], frame.pol};
  wire [DATA_W-1:0] read_mux   = (bus_i.addr == OFS_STATUS)   ? status_rd  :
                                 (bus_i.addr == OFS_CONTROL)  ? control_rd :
                                 (bus_i.addr == OFS_FRAME)    ? frame_rd   :
                                 (bus_i.addr == OFS_BAUD_LOW) ? divisor[DATA_W-1:0] : '0;

  // start low, data LSB first, stop and idle high
  wire line = (state == S_START)  ? 1'b0 :
              (state == S_DATA)   ? shreg[0] :
              (state == S_PARITY) ? par_bit : 1'b1;
  wire busy = (state != S_IDLE) || buf_full;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= '0;
      txd_o <= 1'b1;
      txd_oe_o <= 1'b0;
      buf_irq_o <= 1'b0;
      txc_irq_o <= 1'b0;
    end else begin
      rdata_o <= bus_i.rd ? read_mux : '0;
      txd_o <= line;
      // pin held while enabled or still sending
      txd_oe_o <= tx_en || busy;
      buf_irq_o <= buf_ie && !buf_full;
      txc_irq_o <= txc_ie && tx_done && !txc_clear;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_parity_slot;
    state == S_DATA && step && last_data;
  endsequence
  sequence s_enter_parity;
    ##1 state == S_PARITY;
  endsequence

  a_parity_value: assert property (load |=> par_bit == (^$past(load_data) ^ $past(frame.par_odd)))
    else $error("parity bit is not the xor of the data");
  a_parity_line: assert property (state == S_PARITY |=> txd_o == par_bit)
    else $error("parity slot drives wrong level");
  a_parity_place: assert property (s_parity_slot and frame.par_en |-> s_enter_parity)
    else $error("parity not placed after last data bit");
  a_parity_off: assert property ((!frame.par_en and s_parity_slot) |=> state == S_STOP)
    else $error("parity slot without parity enable");
  a_pin_owner: assert property (tx_en |=> txd_oe_o)
    else $error("data pin not taken over");
  a_write_fill: assert property (wr_data |=> buf_full || state == S_START)
    else $error("data write did not load buffer");
  a_shift_load: assert property (load |=> state == S_START && !buf_full || $past(wr_data))
    else $error("buffer not moved into shifter");
  a_size_mask: assert property (state == S_DATA |-> (shreg >> (nbits - bit_cnt)) == '0)
    else $error("bits above character size reached the shifter");
  a_empty_flag: assert property (status_rd[ST_BUF_EMPTY] == !buf_full)
    else $error("buffer empty flag wrong");
  a_buf_level: assert property (buf_ie && !buf_full && $past(buf_ie && !buf_full) |-> buf_irq_o)
    else $error("buffer empty request dropped");
  a_done_set: assert property (frame_end && !buf_full |=> tx_done)
    else $error("complete flag not set at frame end");
  a_done_clear: assert property (txc_ack_i && !(frame_end && !buf_full) |=> !tx_done)
    else $error("complete flag not cleared");
  a_start_low: assert property (state == S_START |=> !txd_o)
    else $error("start bit not low");
  a_two_stop: assert property (state == S_STOP && step && !stop_cnt && frame.two_stop |=> state == S_STOP)
    else $error("second stop bit missing");

endmodule : stp_serial_tx

// *** test/stp_rx_model.sv ***
// Purpose: remote receiver that samples the transmit line at bit centres
// Assumes: asynchronous frames, bit length given in system clocks
// Notes:   records raw line bits from start bit to last stop, first bit at 0
module stp_rx_model (
  input  wire logic   clk_i,
  input  wire logic   txd_i,
  input  int          bit_clks_i,
  input  int          len_i,
  output logic [12:0] frame_o,
  output int          count_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [12:0] bits;

  initial begin
    frame_o = '0;
    count_o = 0;
  end

  // falling start edge, then one sample per bit on the quiet clock edge
  always begin
    @(negedge txd_i);
    bits = '0;
    repeat (bit_clks_i / 2) @(negedge clk_i);
    for (int i = 0; i < len_i; i++) begin
      bits[i] = txd_i;
      if (i < len_i - 1) repeat (bit_clks_i) @(negedge clk_i);
    end
    frame_o = bits;
    count_o = count_o + 1;
  end
endmodule : stp_rx_model

// *** test/tb.sv ***
// Purpose: register-level test of the serial transmitter
// Assumes: receiver model on the data pin, pull-up on the line
// Notes:   expected frames are built here from the frame settings
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import stp_pkg::*;

  // ----------------------------------------------------------------
  // bench
  // ----------------------------------------------------------------
  logic         clk_i    = 1'b0;
  logic         arst_n_i = 1'b0;
  stp_bus_req_t bus      = '0;
  logic         xck      = 1'b0;
  logic         txc_ack  = 1'b0;
  logic [7:0]   rdata;
  logic         txd, txd_oe, buf_irq, txc_irq;
  wire          txd_line = txd_oe ? txd : 1'b1;  // pull-up while released
  int           fails = 0, compares = 0, bit_clks = 16, len = 11, n, i, k;
  int           rx_count;
  logic [12:0]  rx_frame;
  logic [2:0]   code;
  logic [7:0]   sbits;
  logic [7:0]   frm [5] = '{8'h86, 8'ha8, 8'hb4, 8'hb6, 8'h92};
  logic [7:0]   ctl [5] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h00};
  logic [7:0]   dat [5] = '{8'ha5, 8'hff, 8'h3c, 8'h00, 8'h2a};
  logic [7:0]   div [5] = '{8'h00, 8'h01, 8'h00, 8'h02, 8'h00};
  logic         dbl [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  always #2.5 clk_i = ~clk_i;

  stp_serial_tx stp_serial_tx_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_i(bus), .rdata_o(rdata),
    .txd_o(txd), .txd_oe_o(txd_oe), .xck_i(xck), .txc_ack_i(txc_ack), .buf_irq_o(buf_irq), .txc_irq_o(txc_irq));
  stp_rx_model stp_rx_model_i (.clk_i(clk_i), .txd_i(txd_line), .bit_clks_i(bit_clks), .len_i(len),
    .frame_o(rx_frame), .count_o(rx_count));

  task automatic chk(input logic [12:0] g, input logic [12:0] e, input string m);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input string m);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1;
    chk(13'(rdata), 13'(e), m);
  endtask : rd_chk

  task automatic wait_rx(input int c);
    for (int t = 0; t < 20000 && rx_count < c; t++) @(posedge clk_i);
    chk(13'(rx_count >= c), 13'h1, "frame not received");
  endtask : wait_rx

  // start low, data lsb first, optional parity, stops high
  function automatic logic [12:0] exp_frame(input logic [8:0] d, input int nb, input logic pe, od, two);
    logic [12:0] f;
    logic        p;
    f = '0;
    p = od;
    for (int j = 0; j < nb; j++) begin
      f[1 + j] = d[j];
      p = p ^ d[j];
    end
    f[1 + nb] = pe ? p : 1'b1;
    f[1 + nb + pe] = 1'b1;
    f[2 + nb + pe] = two;
    return f;
  endfunction : exp_frame

  // five-bit synchronous frame, pin clock toggled away from its idle level first
  task automatic sync_frame(input logic [7:0] f, input logic [7:0] d, input logic [6:0] e, input string m);
    wr(OFS_FRAME, f);
    wr(OFS_DATA, d);
    repeat (40) @(posedge clk_i);
    #1;
    chk(13'(txd), 13'h1, "sync frame waits for pin clock");
    for (int j = 0; j < 8; j++) begin
      repeat (16) @(posedge clk_i);
      xck <= ~xck;
      repeat (16) @(posedge clk_i);
      sbits[j] = txd;
      xck <= ~xck;
    end
    chk(13'(sbits[6:0]), 13'(e), m);
  endtask : sync_frame

  task automatic tally_and_finish;
    if (fails == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #200us;
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    chk(13'({txd_oe, buf_irq, txc_irq}), 13'h0, "idle outputs");
    rd_chk(OFS_STATUS, 8'h20, "status reset");
    rd_chk(OFS_CONTROL, 8'h00, "control reset");
    wr(OFS_FRAME, 8'h00);
    rd_chk(OFS_FRAME, 8'h86, "frame kept on divisor write");
    rd_chk(3'h6, 8'h00, "unmapped read");
    rd_chk(OFS_DATA, 8'h00, "data register reads zero");
    for (k = 0; k < 5; k++) begin
      code = {ctl[k][2], frm[k][2:1]};
      n = code == 3'h7 ? 9 : (code < 3'h4 ? 5 + code : 8);
      bit_clks = (dbl[k] ? 8 : 16) * (div[k] + 1);
      len = 2 + n + frm[k][5] + frm[k][3];
      wr(OFS_STATUS, {6'h0, dbl[k], 1'b0});
      wr(OFS_BAUD_LOW, div[k]);
      rd_chk(OFS_BAUD_LOW, div[k], "divisor low readback");
      wr(OFS_FRAME, frm[k]);
      wr(OFS_CONTROL, 8'h68 | ctl[k]);
      repeat (2) @(posedge clk_i);
      #1;
      chk(13'({txd_oe, buf_irq}), 13'h3, "enabled and empty");
      for (i = 0; i < 2; i++) wr(OFS_DATA, i ? ~dat[k] : dat[k]);
      rd_chk(OFS_STATUS, {6'h0, dbl[k], 1'b0}, "second byte waiting");
      chk(13'(buf_irq), 13'h0, "empty request with full buffer");
      for (i = 0; i < 2; i++) begin
        wait_rx(2 * k + i + 1);
        chk(rx_frame, exp_frame({ctl[k][0], i ? ~dat[k] : dat[k]}, n, frm[k][5], frm[k][4], frm[k][3]),
          "frame bits");
      end
      repeat (bit_clks + 4) @(posedge clk_i);
      #1;
      chk(13'(txc_irq), 13'h1, "complete request");
      rd_chk(OFS_STATUS, 8'h60 | {6'h0, dbl[k], 1'b0}, "complete and empty");
      if (k % 2) begin
        @(posedge clk_i);
        txc_ack <= 1'b1;
        @(posedge clk_i);
        txc_ack <= 1'b0;
      end else begin
        wr(OFS_STATUS, {6'h10, dbl[k], 1'b0});
      end
      repeat (2) @(posedge clk_i);
      #1;
      chk(13'(txc_irq), 13'h0, "complete request cleared");
      rd_chk(OFS_STATUS, 8'h20 | {6'h0, dbl[k], 1'b0}, "complete flag cleared");
    end
    wr(OFS_STATUS, 8'h00);
    wr(OFS_CONTROL, 8'h68);
    sync_frame(8'hc0, 8'h16, 7'h6c, "sync frame bits on rising pin edge");
    @(posedge clk_i);
    xck <= 1'b1;
    sync_frame(8'hc1, 8'he9, 7'h52, "sync frame bits on falling pin edge");
    tally_and_finish();
  end
endmodule : tb
